// file: logic/image_sample_opcode_decoder.sv
// Purpose: Decodes image sampling, fetch, query and ray opcodes.
// Assumes: Issue and writeback run on mclk; inputs are same-domain.
// Notes: One register stage each way; rejected opcodes never dispatch.
//
// What this block does
// (RL1) Opcode 36 samples at given level, 37 with bias, 39 level zero.
// (RL2) Opcode 35 samples with user derivatives and shader detail clamp.
// (RL3) Opcode 40 adds depth compare; up to 47 compare with modifiers.
// (RL4) Opcodes 48 to 63 repeat sampling variants with texel offsets.
// (RL5) Opcode 64 fetches one component from a 2x2 footprint, unfiltered.
// (RL6) Fetch variants 65 to 79 add clamp, level, bias, zero, compare.
// (RL7) Opcodes 80 to 95 are the fetch variants with texel offsets.
// (RL8) Opcode 96 returns clamped then raw detail level, 32-bit floats.
// (RL9) Opcode 97 fetches one masked component from a 4x1 texel row.
// (RL10) Issuer sets exactly one bit of the component select mask.
// (RL11) Opcode 128 loads up to 4 samples at a fragment, no sampler.
// (RL12) Opcodes 162 to 187 are derivative variants with 16-bit gradients.
// (RL13) Opcode 230 tests a ray against a node via 32-bit pointer.
// (RL14) Box node returns 4 child pointers sorted by intersection time.
// (RL15) Triangle node returns intersection time and triangle identifier.
// (RL16) Full precision ray form reads 11 consecutive address registers.
// (RL17) Address order: pointer, extent, origin, direction, inverse.
// (RL18) Half precision flag packs directions, reading eight registers.
// (RL19) Issuer sets the wide descriptor flag for the ray operation.
// (RL20) Unassigned opcodes are flagged unsupported and not dispatched.
`timescale 1ns/100ps
`include "sample_decode_map.svh"
module image_sample_opcode_decoder
   import sample_decode_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Instruction issue.
   input wire logic issue_valid,
   output logic issue_ready,
   input wire logic [7:0] issue_opcode,
   input wire logic [3:0] component_select_mask,
   input wire logic half_precision_address_flag,
   input wire logic wide_descriptor_flag,
   // Dispatch to the address and filter pipeline.
   output logic disp_valid,
   input wire logic disp_ready,
   output op_class_t disp_class,
   output logic disp_depth_cmp,
   output logic disp_detail_clamp,
   output logic disp_user_deriv,
   output logic disp_explicit_level,
   output logic disp_detail_bias,
   output logic disp_level_zero,
   output logic disp_texel_offset,
   output logic half_gradient_variant,
   output logic disp_uses_sampler,
   output logic [3:0] disp_comp_mask,
   output logic [3:0] disp_addr_regs,
   output logic [3:0] disp_dir_reg,
   output logic [3:0] disp_inv_dir_reg,
   output logic [2:0] disp_result_regs,
   output logic reject_pulse,
   // Results from the pipeline.
   input wire logic wb_valid,
   input wire op_class_t wb_class,
   input wire logic [31:0] wb_lod_clamped,
   input wire logic [31:0] wb_lod_raw,
   input wire logic wb_node_is_box,
   input wire logic [3:0][31:0] wb_child_ptr,
   input wire logic [3:0][31:0] wb_child_time,
   input wire logic [31:0] wb_tri_time,
   input wire logic [31:0] wb_tri_id,
   // Register writeback.
   output logic result_valid,
   output logic [3:0][31:0] result_vector_regs,
   output logic [2:0] result_count
);

   function automatic logic [2:0] bit_count(input logic [3:0] m);
      bit_count = {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]}
         + {2'b00, m[3]};
   endfunction

   function automatic logic one_hot(input logic [3:0] m);
      one_hot = (bit_count(m) == 3'h1);
   endfunction

   logic [2:0] family;
   logic [2:0] variant;
   logic mod_clamp;
   logic mod_deriv;
   logic mod_level;
   logic mod_bias;
   logic mod_zero;

   assign family = issue_opcode[`FAMILY_MSB:`FAMILY_LSB];
   assign variant = issue_opcode[`VARIANT_MSB:0];

   variant_modifier_decode u_variant (
      .variant(variant),
      .detail_clamp(mod_clamp),
      .user_deriv(mod_deriv),
      .explicit_level(mod_level),
      .detail_bias(mod_bias),
      .level_zero(mod_zero)
   );

   // Decode stage.
   op_class_t cls;
   logic cmp;
   logic ofs;
   logic half_grad;
   logic use_mods;
   logic legal;
   logic accept;

   always_comb begin
      cls = cls_none;
      cmp = 1'b0;
      ofs = 1'b0;
      half_grad = 1'b0;
      use_mods = 1'b0;
      legal = 1'b0;
      if (family == `FAMILY_SAMPLE) begin
         cls = cls_sample; // RL1
         cmp = issue_opcode[`COMPARE_BIT]; // RL3
         ofs = issue_opcode[`OFFSET_BIT]; // RL4
         use_mods = 1'b1; // RL2
         legal = 1'b1;
      end else if (family == `FAMILY_FETCH4) begin
         cls = cls_fetch4; // RL5
         cmp = issue_opcode[`COMPARE_BIT]; // RL6
         ofs = issue_opcode[`OFFSET_BIT]; // RL7
         use_mods = 1'b1; // RL6
         // Derivative codes have no fetch form, e.g. 66, 67, 74, 75.
         legal = !mod_deriv; // RL20
      end else if (family == `FAMILY_HALF_GRAD) begin
         cls = cls_sample; // RL12
         cmp = issue_opcode[`COMPARE_BIT]; // RL12
         ofs = issue_opcode[`OFFSET_BIT]; // RL12
         half_grad = 1'b1; // RL12
         use_mods = 1'b1;
         legal = mod_deriv; // RL20
      end else begin
         unique case (issue_opcode)
            `OPC_LOD_QUERY: begin
               cls = cls_lod_query; // RL8
               legal = 1'b1;
            end
            `OPC_ROW_FETCH: begin
               cls = cls_row_fetch; // RL9
               // A malformed mask would pick no or several components.
               legal = one_hot(component_select_mask); // RL10
            end
            `OPC_MS_LOAD: begin
               cls = cls_ms_load; // RL11
               legal = 1'b1;
            end
            `OPC_RAY_ISECT: begin
               cls = cls_ray_isect; // RL13
               legal = wide_descriptor_flag; // RL19
            end
            default: legal = 1'b0; // RL20
         endcase
      end
   end

   assign issue_ready = !disp_valid || disp_ready;
   assign accept = issue_valid && issue_ready;

   // Dispatch register group.
   op_class_t class_q, class_d;
   logic valid_q, valid_d;
   logic reject_q, reject_d;
   logic [8:1] mods_q, mods_d;
   logic uses_q, uses_d;
   logic [3:0] mask_q, mask_d;
   logic [3:0] addr_q, addr_d;
   logic [3:0] dir_q, dir_d;
   logic [3:0] inv_q, inv_d;
   logic [2:0] res_q, res_d;

   always_comb begin
      class_d = class_q;
      valid_d = valid_q;
      reject_d = 1'b0;
      mods_d = mods_q;
      uses_d = uses_q;
      mask_d = mask_q;
      addr_d = addr_q;
      dir_d = dir_q;
      inv_d = inv_q;
      res_d = res_q;
      if (accept) begin
         valid_d = legal; // RL20
         reject_d = !legal; // RL20
         class_d = legal ? cls : cls_none;
         mods_d = {cmp, use_mods & mod_clamp, use_mods & mod_deriv,
            use_mods & mod_level, use_mods & mod_bias,
            use_mods & mod_zero, ofs, half_grad};
         uses_d = !(cls == cls_ms_load || cls == cls_ray_isect); // RL11
         mask_d = component_select_mask;
         addr_d = 4'h0;
         dir_d = 4'h0;
         inv_d = 4'h0;
         res_d = `RES_REGS_FOUR;
         unique case (cls)
            cls_sample: res_d = bit_count(component_select_mask);
            cls_ms_load: res_d = bit_count(component_select_mask); // RL11
            cls_lod_query: res_d = `RES_REGS_TWO; // RL8
            cls_ray_isect: begin
               res_d = `RES_REGS_FOUR; // RL14
               dir_d = `RAY_REG_DIR; // RL17
               if (half_precision_address_flag) begin
                  addr_d = `RAY_ADDR_REGS_HALF; // RL18
                  // Inverse direction starts mid-register when packed.
                  inv_d = `RAY_REG_DIR + 4'h1; // RL18
               end else begin
                  addr_d = `RAY_ADDR_REGS_FULL; // RL16
                  inv_d = `RAY_REG_INV_DIR_FULL; // RL17
               end
            end
            default: res_d = `RES_REGS_FOUR; // RL5
         endcase
         if (!legal) begin
            res_d = `RES_REGS_NONE;
         end
      end else if (disp_ready) begin
         valid_d = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         class_q <= cls_none;
         valid_q <= 1'b0;
         reject_q <= 1'b0;
         mods_q <= 8'h00;
         uses_q <= 1'b0;
         mask_q <= 4'h0;
         addr_q <= 4'h0;
         dir_q <= 4'h0;
         inv_q <= 4'h0;
         res_q <= 3'h0;
      end else begin
         class_q <= class_d;
         valid_q <= valid_d;
         reject_q <= reject_d;
         mods_q <= mods_d;
         uses_q <= uses_d;
         mask_q <= mask_d;
         addr_q <= addr_d;
         dir_q <= dir_d;
         inv_q <= inv_d;
         res_q <= res_d;
      end
   end

   assign disp_valid = valid_q;
   assign reject_pulse = reject_q;
   assign disp_class = class_q;
   assign disp_depth_cmp = mods_q[8];
   assign disp_detail_clamp = mods_q[7];
   assign disp_user_deriv = mods_q[6];
   assign disp_explicit_level = mods_q[5];
   assign disp_detail_bias = mods_q[4];
   assign disp_level_zero = mods_q[3];
   assign disp_texel_offset = mods_q[2];
   assign half_gradient_variant = mods_q[1];
   assign disp_uses_sampler = uses_q;
   assign disp_comp_mask = mask_q;
   assign disp_addr_regs = addr_q;
   assign disp_dir_reg = dir_q;
   assign disp_inv_dir_reg = inv_q;
   assign disp_result_regs = res_q;

   // Writeback group. Times compare as unsigned bit patterns, which
   // orders non-negative floats correctly; hits carry no negative time.
   // Neighbour swaps on a strict less keep equal times in index order.
   localparam int unsigned net_lo [6] = '{0, 2, 1, 0, 2, 1};
   localparam int unsigned net_hi [6] = '{1, 3, 2, 1, 3, 2};

   logic rvalid_q, rvalid_d;
   logic [3:0][31:0] rregs_q, rregs_d;
   logic [2:0] rcount_q, rcount_d;
   logic [3:0][31:0] key;
   logic [3:0][31:0] ptr;
   logic [31:0] tmp;

   always_comb begin
      key = wb_child_time;
      ptr = wb_child_ptr;
      tmp = 32'h0000_0000;
      for (int s = 0; s < 6; s++) begin
         if (key[net_hi[s]] < key[net_lo[s]]) begin
            tmp = key[net_lo[s]];
            key[net_lo[s]] = key[net_hi[s]];
            key[net_hi[s]] = tmp; // RL14
            tmp = ptr[net_lo[s]];
            ptr[net_lo[s]] = ptr[net_hi[s]];
            ptr[net_hi[s]] = tmp; // RL14
         end
      end
      rvalid_d = 1'b0;
      rregs_d = rregs_q;
      rcount_d = rcount_q;
      if (wb_valid && wb_class == cls_lod_query) begin
         rvalid_d = 1'b1;
         rregs_d = {64'h0, wb_lod_raw, wb_lod_clamped}; // RL8
         rcount_d = `RES_REGS_TWO; // RL8
      end else if (wb_valid && wb_class == cls_ray_isect) begin
         rvalid_d = 1'b1;
         if (wb_node_is_box) begin
            rregs_d = ptr; // RL14
            rcount_d = `RES_REGS_FOUR; // RL14
         end else begin
            rregs_d = {64'h0, wb_tri_id, wb_tri_time}; // RL15
            rcount_d = `RES_REGS_TWO; // RL15
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_q <= 1'b0;
         rregs_q <= '0;
         rcount_q <= 3'h0;
      end else begin
         rvalid_q <= rvalid_d;
         rregs_q <= rregs_d;
         rcount_q <= rcount_d;
      end
   end

   assign result_valid = rvalid_q;
   assign result_vector_regs = rregs_q;
   assign result_count = rcount_q;

endmodule // image_sample_opcode_decoder

// file: logic/sample_decode_map.svh
// Purpose: Opcode values, ray address layout and result counts.
// Assumes: Opcodes are the 8-bit image instruction opcode field.
// Notes: Definitions only.
`ifndef SAMPLE_DECODE_MAP_SVH
`define SAMPLE_DECODE_MAP_SVH

// Sampling family occupies 32..63, four-texel fetch 64..95.
`define OPC_SAMPLE_D_CL 8'h23
`define OPC_SAMPLE_L 8'h24
`define OPC_SAMPLE_B 8'h25
`define OPC_SAMPLE_LZ 8'h27
`define OPC_SAMPLE_C 8'h28
`define OPC_SAMPLE_C_LAST 8'h2f
`define OPC_SAMPLE_O_FIRST 8'h30
`define OPC_SAMPLE_O_LAST 8'h3f
`define OPC_FETCH4 8'h40
`define OPC_FETCH4_LZ 8'h47
`define OPC_FETCH4_C 8'h48
`define OPC_FETCH4_C_LAST 8'h4f
`define OPC_FETCH4_O_FIRST 8'h50
`define OPC_FETCH4_O_LAST 8'h5f
`define OPC_LOD_QUERY 8'h60
`define OPC_ROW_FETCH 8'h61
`define OPC_MS_LOAD 8'h80
`define OPC_HALF_GRAD_FIRST 8'ha2
`define OPC_HALF_GRAD_LAST 8'hbb
`define OPC_RAY_ISECT 8'he6

// Field positions inside the opcode of the sampling families.
`define FAMILY_MSB 7
`define FAMILY_LSB 5
`define OFFSET_BIT 4
`define COMPARE_BIT 3
`define VARIANT_MSB 2
`define FAMILY_SAMPLE 3'h1
`define FAMILY_FETCH4 3'h2
`define FAMILY_HALF_GRAD 3'h5

// Ray address registers, full and half precision direction layout.
`define RAY_ADDR_REGS_FULL 4'hb
`define RAY_ADDR_REGS_HALF 4'h8
`define RAY_REG_NODE_PTR 4'h0
`define RAY_REG_EXTENT 4'h1
`define RAY_REG_ORIGIN 4'h2
`define RAY_REG_DIR 4'h5
`define RAY_REG_INV_DIR_FULL 4'h8

// Result register counts.
`define RES_REGS_FOUR 3'h4
`define RES_REGS_TWO 3'h2
`define RES_REGS_NONE 3'h0

`endif

// file: logic/sample_decode_pkg.sv
// Purpose: Types shared by the image opcode decoder files.
// Assumes: Nothing beyond the map header.
// Notes: Class codes are carried on the dispatch and writeback ports.
package sample_decode_pkg;

   typedef enum logic [2:0] {
      cls_none = 3'b000,
      cls_sample = 3'b001,
      cls_fetch4 = 3'b010,
      cls_lod_query = 3'b011,
      cls_row_fetch = 3'b100,
      cls_ms_load = 3'b101,
      cls_ray_isect = 3'b110
   } op_class_t;

endpackage

// file: logic/variant_modifier_decode.sv
// Purpose: Turns the three low opcode bits into sampling modifiers.
// Assumes: Caller has already picked the sampling or fetch family.
// Notes: Pure combinational; shared by every family.
`timescale 1ns/100ps
`include "sample_decode_map.svh"
module variant_modifier_decode
   import sample_decode_pkg::*;
(
   // Variant code.
   input wire logic [2:0] variant,
   // Modifiers.
   output logic detail_clamp,
   output logic user_deriv,
   output logic explicit_level,
   output logic detail_bias,
   output logic level_zero
);

   // Codes: 0 plain, 1 clamp, 2 deriv, 3 deriv+clamp, 4 level,
   // 5 bias, 6 bias+clamp, 7 level zero.
   always_comb begin
      detail_clamp = 1'b0;
      user_deriv = 1'b0;
      explicit_level = 1'b0;
      detail_bias = 1'b0;
      level_zero = 1'b0;
      unique case (variant)
         3'h0: ;
         3'h1: detail_clamp = 1'b1;
         3'h2: user_deriv = 1'b1;
         3'h3: begin
            user_deriv = 1'b1; // RL2
            detail_clamp = 1'b1; // RL2
         end
         3'h4: explicit_level = 1'b1; // RL1
         3'h5: detail_bias = 1'b1; // RL1
         3'h6: begin
            detail_bias = 1'b1;
            detail_clamp = 1'b1;
         end
         3'h7: level_zero = 1'b1; // RL1
      endcase
   end

endmodule // variant_modifier_decode

// file: tb/far_pipeline_model.sv
// Purpose: Filter pipeline and result source beyond the decoder.
// Assumes: send is called from the bench at a falling edge.
// Notes: Result data changes every cycle, so a stale capture shows.
`timescale 1ns/100ps
module far_pipeline_model
   import sample_decode_pkg::*;
(
   // Clock.
   input wire logic mclk,
   // Dispatch acceptance.
   output logic disp_ready,
   // Results.
   output logic wb_valid,
   output op_class_t wb_class,
   output logic wb_node_is_box,
   output logic [31:0] wb_lod_clamped,
   output logic [31:0] wb_lod_raw,
   output logic [31:0] wb_tri_time,
   output logic [31:0] wb_tri_id,
   output logic [3:0][31:0] wb_child_ptr,
   output logic [3:0][31:0] wb_child_time
);
   int seed = 7;
   initial begin
      disp_ready = 1'b1;
      wb_valid = 1'b0;
      wb_class = cls_none;
      wb_node_is_box = 1'b0;
   end
   // Stalls about one cycle in four; small times make ties common.
   always @(negedge mclk) begin
      disp_ready <= ($random(seed) & 3) != 0;
      wb_lod_clamped <= $random(seed);
      wb_lod_raw <= $random(seed);
      wb_tri_time <= $random(seed);
      wb_tri_id <= $random(seed);
      for (int i = 0; i < 4; i++) begin
         wb_child_ptr[i] <= $random(seed);
         wb_child_time[i] <= 32'($random(seed) & 3);
      end
   end
   task automatic send(input op_class_t c, input logic box);
      wb_class = c;
      wb_node_is_box = box;
      wb_valid = 1'b1;
      @(negedge mclk);
      wb_valid = 1'b0;
   endtask
endmodule // far_pipeline_model

// file: tb/image_sample_opcode_decoder_chk.sv
// Purpose: Port-level checks on the image opcode decoder.
// Assumes: One mclk domain; arst_n is asynchronous and active low.
// Notes: Bound to every decoder instance.
`timescale 1ns/100ps
module image_sample_opcode_decoder_chk
   import sample_decode_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Issue.
   input wire logic issue_valid,
   input wire logic issue_ready,
   input wire logic [7:0] issue_opcode,
   input wire logic wide_descriptor_flag,
   // Dispatch.
   input wire logic disp_valid,
   input wire op_class_t disp_class,
   input wire logic disp_level_zero,
   input wire logic disp_uses_sampler,
   input wire logic [3:0] disp_comp_mask,
   input wire logic [3:0] disp_addr_regs,
   input wire logic [3:0] disp_dir_reg,
   input wire logic [3:0] disp_inv_dir_reg,
   input wire logic [2:0] disp_result_regs,
   input wire logic reject_pulse,
   // Writeback.
   input wire logic wb_valid,
   input wire op_class_t wb_class,
   input wire logic [31:0] wb_lod_clamped,
   input wire logic [31:0] wb_lod_raw,
   input wire logic result_valid,
   input wire logic [3:0][31:0] result_vector_regs,
   input wire logic [2:0] result_count
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic took;
   assign took = issue_valid && issue_ready;
   property p_lz;
      took && issue_opcode == 8'h27 |=> disp_valid && disp_level_zero &&
         disp_class == cls_sample;
   endproperty
   a_lz: assert property (p_lz)
      else $error("level zero sample not dispatched");
   property p_unassigned;
      took && issue_opcode inside {8'h42, 8'h43, 8'h4a, 8'h4b, 8'he7}
         |=> reject_pulse && !disp_valid;
   endproperty
   a_unassigned: assert property (p_unassigned)
      else $error("unassigned opcode not refused");
   property p_ray_wide;
      took && issue_opcode == 8'he6 && !wide_descriptor_flag |=> reject_pulse;
   endproperty
   a_ray_wide: assert property (p_ray_wide)
      else $error("ray op without wide descriptor accepted");
   property p_ray_addr;
      disp_valid && disp_class == cls_ray_isect |-> disp_dir_reg == 4'h5 &&
         (disp_addr_regs == 4'hb && disp_inv_dir_reg == 4'h8 ||
         disp_addr_regs == 4'h8 && disp_inv_dir_reg == 4'h6);
   endproperty
   a_ray_addr: assert property (p_ray_addr)
      else $error("ray address layout wrong");
   property p_sampler;
      disp_valid && disp_class != cls_none |-> disp_uses_sampler ==
         !(disp_class inside {cls_ms_load, cls_ray_isect});
   endproperty
   a_sampler: assert property (p_sampler)
      else $error("sampler use wrong for class");
   property p_row;
      disp_valid && disp_class == cls_row_fetch |-> $onehot(disp_comp_mask)
         && disp_result_regs == 3'h4;
   endproperty
   a_row: assert property (p_row)
      else $error("row fetch mask or count wrong");
   property p_lod;
      wb_valid && wb_class == cls_lod_query |=> result_valid &&
         result_count == 3'h2 &&
         result_vector_regs[0] == $past(wb_lod_clamped) &&
         result_vector_regs[1] == $past(wb_lod_raw);
   endproperty
   a_lod: assert property (p_lod)
      else $error("detail level result wrong");
   property p_res_cause;
      result_valid |-> $past(wb_valid) &&
         $past(wb_class) inside {cls_lod_query, cls_ray_isect};
   endproperty
   a_res_cause: assert property (p_res_cause)
      else $error("result without a matching writeback");
endmodule // image_sample_opcode_decoder_chk

bind image_sample_opcode_decoder image_sample_opcode_decoder_chk
   image_sample_opcode_decoder_chk_i (.mclk, .arst_n, .issue_valid,
   .issue_ready, .issue_opcode, .wide_descriptor_flag, .disp_valid,
   .disp_class, .disp_level_zero, .disp_uses_sampler, .disp_comp_mask,
   .disp_addr_regs, .disp_dir_reg, .disp_inv_dir_reg, .disp_result_regs,
   .reject_pulse, .wb_valid, .wb_class, .wb_lod_clamped, .wb_lod_raw,
   .result_valid, .result_vector_regs, .result_count);

// file: tb/image_sample_opcode_decoder_tb.sv
// Purpose: Self-checking bench for the image opcode decoder.
// Assumes: The partner model stalls dispatch and posts results.
// Notes: Every opcode value is issued with random mask and flags.
`timescale 1ns/100ps
module image_sample_opcode_decoder_tb
   import sample_decode_pkg::*;
;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic issue_valid = 1'b0;
   logic [7:0] issue_opcode = 8'h00;
   logic [3:0] component_select_mask = 4'h0;
   logic half_precision_address_flag = 1'b0;
   logic wide_descriptor_flag = 1'b0;
   logic issue_ready, disp_valid, disp_ready, reject_pulse, result_valid;
   logic disp_depth_cmp, disp_detail_clamp, disp_user_deriv;
   logic disp_explicit_level, disp_detail_bias, disp_level_zero;
   logic disp_texel_offset, half_gradient_variant, disp_uses_sampler;
   logic [3:0] disp_comp_mask, disp_addr_regs, disp_dir_reg, disp_inv_dir_reg;
   logic [2:0] disp_result_regs, result_count;
   op_class_t disp_class, wb_class;
   logic wb_valid, wb_node_is_box;
   logic [31:0] wb_lod_clamped, wb_lod_raw, wb_tri_time, wb_tri_id;
   logic [3:0][31:0] wb_child_ptr, wb_child_time, result_vector_regs;
   int err_count = 0;
   int check_count = 0;
   int seed = 44;
   always #25 mclk = ~mclk;
   image_sample_opcode_decoder image_sample_opcode_decoder_i (.mclk, .arst_n,
      .issue_valid, .issue_ready, .issue_opcode, .component_select_mask,
      .half_precision_address_flag, .wide_descriptor_flag, .disp_valid,
      .disp_ready, .disp_class, .disp_depth_cmp, .disp_detail_clamp,
      .disp_user_deriv, .disp_explicit_level, .disp_detail_bias,
      .disp_level_zero, .disp_texel_offset, .half_gradient_variant,
      .disp_uses_sampler, .disp_comp_mask, .disp_addr_regs, .disp_dir_reg,
      .disp_inv_dir_reg, .disp_result_regs, .reject_pulse, .wb_valid,
      .wb_class, .wb_lod_clamped, .wb_lod_raw, .wb_node_is_box,
      .wb_child_ptr, .wb_child_time, .wb_tri_time, .wb_tri_id,
      .result_valid, .result_vector_regs, .result_count);
   far_pipeline_model far_pipeline_model_i (.mclk, .disp_ready, .wb_valid,
      .wb_class, .wb_node_is_box, .wb_lod_clamped, .wb_lod_raw,
      .wb_tri_time, .wb_tri_id, .wb_child_ptr, .wb_child_time);
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [127:0] e, s);
      check_count++;
      if (e !== s) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Zero class in the result means the opcode must be refused.
   function automatic logic [30:0] expect_dec(input logic [7:0] o,
      input logic [3:0] m, input logic h, input logic w);
      logic [2:0] c, r, lo;
      logic [8:0] f;
      logic [3:0] a, d, v;
      lo = o[2:0];
      c = 3'h0;
      f = 9'h0;
      a = 4'h0;
      d = 4'h0;
      v = 4'h0;
      r = 3'h0;
      if ((o >= 8'h20 && o <= 8'h5f && !(o >= 8'h40 && lo inside {2, 3}))
         || (o >= 8'ha2 && o <= 8'hbb && lo inside {2, 3})) begin
         c = (o >= 8'h40 && o <= 8'h5f) ? 3'h2 : 3'h1;
         f = {o[3], lo inside {1, 3, 6}, lo inside {2, 3}, lo == 3'h4,
            lo inside {5, 6}, lo == 3'h7, o[4], o >= 8'ha2, 1'b1};
         r = (c == 3'h2) ? 3'h4 : 3'($countones(m));
      end else if (o == 8'h60) begin
         c = 3'h3;
         f = 9'h1;
         r = 3'h2;
      end else if (o == 8'h61 && $onehot(m)) begin
         c = 3'h4;
         f = 9'h1;
         r = 3'h4;
      end else if (o == 8'h80) begin
         c = 3'h5;
         r = 3'($countones(m));
      end else if (o == 8'he6 && w) begin
         c = 3'h6;
         r = 3'h4;
         a = h ? 4'h8 : 4'hb;
         d = 4'h5;
         v = h ? 4'h6 : 4'h8;
      end
      return {c, f, m, a, d, v, r};
   endfunction
   task automatic issue(input logic [7:0] o, input logic [3:0] m,
      input logic h, input logic w);
      logic [30:0] e;
      int n;
      e = expect_dec(o, m, h, w);
      issue_opcode = o;
      component_select_mask = m;
      half_precision_address_flag = h;
      wide_descriptor_flag = w;
      issue_valid = 1'b1;
      n = 0;
      #1;
      while (issue_ready !== 1'b1 && n < 50) begin
         @(negedge mclk);
         #1;
         n++;
      end
      if (n == 50) begin
         err_count++;
         wrap_up();
      end
      @(negedge mclk);
      if (e[30:28] == 3'h0) begin
         chk("refusal", 2'b01, {disp_valid, reject_pulse});
      end else begin
         chk("dispatch", {2'b10, e}, {disp_valid, reject_pulse,
            disp_class, disp_depth_cmp, disp_detail_clamp, disp_user_deriv,
            disp_explicit_level, disp_detail_bias, disp_level_zero,
            disp_texel_offset, half_gradient_variant, disp_uses_sampler,
            disp_comp_mask, disp_addr_regs, disp_dir_reg, disp_inv_dir_reg,
            disp_result_regs});
      end
   endtask
   task automatic wb(input op_class_t c, input logic box);
      logic [127:0] e;
      int idx[$];
      int j;
      fork
         far_pipeline_model_i.send(c, box);
         begin
            #1;
            e = {64'h0, wb_lod_raw, wb_lod_clamped};
            if (c == cls_ray_isect) e = {64'h0, wb_tri_id, wb_tri_time};
            for (int i = 0; i < 4; i++) begin
               j = 0;
               while (j < idx.size() &&
                  wb_child_time[idx[j]] <= wb_child_time[i]) j++;
               idx.insert(j, i);
            end
            if (c == cls_ray_isect && box) begin
               for (int i = 0; i < 4; i++) e[32*i +: 32] = wb_child_ptr[idx[i]];
            end
         end
      join
      chk("result_valid", c inside {cls_lod_query, cls_ray_isect},
         result_valid);
      if (c inside {cls_lod_query, cls_ray_isect}) begin
         chk("result regs", e, box ? result_vector_regs :
            {64'h0, result_vector_regs[1:0]});
         chk("result count", box ? 3'h4 : 3'h2, result_count);
      end
      @(negedge mclk);
   endtask
   initial begin
      repeat (8) @(negedge mclk);
      arst_n = 1'b1;
      @(negedge mclk);
      for (int o = 0; o < 256; o++) begin
         issue(o[7:0], 4'($random(seed)), 1'($random(seed)),
            ($random(seed) & 3) != 0);
      end
      issue(8'h61, 4'h3, 1'b0, 1'b1);
      issue(8'h61, 4'h8, 1'b0, 1'b1);
      issue(8'he6, 4'hf, 1'b1, 1'b1);
      issue(8'he6, 4'hf, 1'b0, 1'b1);
      issue(8'he6, 4'hf, 1'b0, 1'b0);
      issue(8'h80, 4'h7, 1'b0, 1'b1);
      issue_valid = 1'b0;
      @(negedge mclk);
      repeat (20) begin
         wb(cls_lod_query, 1'b0);
         wb(cls_ray_isect, 1'b1);
         wb(cls_ray_isect, 1'b0);
         wb(cls_sample, 1'b0);
      end
      wrap_up();
   end
endmodule // image_sample_opcode_decoder_tb
